// File: design/pich_cyc_if.sv
// request and answer between the sequencer and the pin cycle engine
`timescale 1ns/1ps
interface pich_cyc_if;
  logic start;
  pich_pkg::pich_cyc_type kind;
  logic a0;
  logic [7:0] wdata;
  logic done;
  logic [7:0] rdata;
  modport seq (output start, output kind, output a0, output wdata, input done, input rdata);
  modport eng (input start, input kind, input a0, input wdata, output done, output rdata);
endinterface : pich_cyc_if

// File: design/pich_cycle.sv
// pin cycle engine: one read, write or acknowledge strobe with its recovery time
`timescale 1ns/1ps
`include "pich_map.svh"
module pich_cycle #(
  parameter int RD_LOW = `PICH_CYC(`PICH_RD_LOW_NS),
  parameter int WR_LOW = `PICH_CYC(`PICH_WR_LOW_NS),
  parameter int ACK_LOW = `PICH_CYC(`PICH_ACK_LOW_NS),
  parameter int RECOVER = `PICH_CYC(`PICH_RECOVER_NS)
) (
  input wire logic clk, // system clock
  input wire logic reset_n, // synchronous reset, active low
  pich_cyc_if.eng cyc, // request from the sequencer
  output logic cs_n, // chip select, active low
  output logic rd_n, // read strobe, active low
  output logic wr_n, // write strobe, active low
  output logic int_ack_n, // acknowledge strobe, active low
  output logic addr_bit0, // register select
  output logic [7:0] d_out, // data toward the device
  output logic d_oe_n, // low while driving the data bus
  input wire logic [7:0] d_in // data from the device
);
  initial begin
    if (RD_LOW < 1 || RD_LOW > 15 || WR_LOW < 1 || WR_LOW > 15 || ACK_LOW < 1 ||
        ACK_LOW > 15 || RECOVER < 1 || RECOVER > 15) begin
      $error("pich_cycle: strobe counts must lie in 1..15");
    end
  end

  typedef struct packed {
    pich_pkg::pich_phase_type ph;
    logic [3:0] cnt;
    pich_pkg::pich_cyc_type kind;
    logic done;
    logic [7:0] rdata;
    logic cs_n;
    logic rd_n;
    logic wr_n;
    logic ack_n;
    logic a0;
    logic [7:0] dout;
    logic oe_n;
  } pich_eng_type;

  pich_eng_type s_q;
  pich_eng_type s_d;

  // low time for each kind of strobe
  function automatic logic [3:0] low_cycles(input pich_pkg::pich_cyc_type k);
    case (k)
      pich_pkg::CYC_WRITE: low_cycles = 4'(WR_LOW);
      pich_pkg::CYC_READ: low_cycles = 4'(RD_LOW);
      default: low_cycles = 4'(ACK_LOW);
    endcase
  endfunction : low_cycles

  // strobe sequencing; data sampled at the last low cycle, after the access time
  always_comb begin
    s_d = s_q;
    s_d.done = 1'b0;
    case (s_q.ph)
      pich_pkg::PH_IDLE: begin
        if (cyc.start) begin
          s_d.kind = cyc.kind;
          s_d.a0 = cyc.a0;
          s_d.dout = cyc.wdata;
          s_d.cnt = low_cycles(cyc.kind) - 4'h1;
          s_d.cs_n = (cyc.kind == pich_pkg::CYC_ACK);
          s_d.rd_n = (cyc.kind != pich_pkg::CYC_READ);
          s_d.wr_n = (cyc.kind != pich_pkg::CYC_WRITE);
          s_d.ack_n = (cyc.kind != pich_pkg::CYC_ACK);
          s_d.oe_n = (cyc.kind != pich_pkg::CYC_WRITE);
          s_d.ph = pich_pkg::PH_LOW;
        end
      end
      pich_pkg::PH_LOW: begin
        if (s_q.cnt == 4'h0) begin
          if (s_q.kind != pich_pkg::CYC_WRITE) begin
            s_d.rdata = d_in;
          end
          s_d.cs_n = 1'b1;
          s_d.rd_n = 1'b1;
          s_d.wr_n = 1'b1;
          s_d.ack_n = 1'b1;
          s_d.oe_n = 1'b1; // hold time is zero, so release with the strobe
          s_d.cnt = 4'(RECOVER) - 4'h1;
          s_d.ph = pich_pkg::PH_REC;
        end else begin
          s_d.cnt = s_q.cnt - 4'h1;
        end
      end
      pich_pkg::PH_REC: begin
        // recovery keeps back-to-back strobes legal for the device
        if (s_q.cnt == 4'h0) begin
          s_d.done = 1'b1;
          s_d.ph = pich_pkg::PH_IDLE;
        end else begin
          s_d.cnt = s_q.cnt - 4'h1;
        end
      end
      default: s_d.ph = pich_pkg::PH_IDLE;
    endcase
    if (!reset_n) begin
      s_d = '0;
      s_d.ph = pich_pkg::PH_IDLE;
      s_d.cs_n = 1'b1;
      s_d.rd_n = 1'b1;
      s_d.wr_n = 1'b1;
      s_d.ack_n = 1'b1;
      s_d.oe_n = 1'b1;
    end
  end

  // state register
  always_ff @(posedge clk) begin
    s_q <= s_d;
  end

  assign cyc.done = s_q.done;
  assign cyc.rdata = s_q.rdata;
  assign cs_n = s_q.cs_n;
  assign rd_n = s_q.rd_n;
  assign wr_n = s_q.wr_n;
  assign int_ack_n = s_q.ack_n;
  assign addr_bit0 = s_q.a0;
  assign d_out = s_q.dout;
  assign d_oe_n = s_q.oe_n;
endmodule : pich_cycle

// File: design/pich_host.sv
// host controller for an eight-input interrupt unit, software side on avalon-mm
// Function
// - host software uses specific end-of-interrupt after priority changes or exceptional nesting.
// - peripheral holds its request high until acknowledge reaches the device.
// - level 7 reserved for incomplete interrupts; its handler sends no end-of-interrupt.
// - pending poll sets in-service bit; host must later end that level.
// - host disables its interrupt input before polling and polls with address 0.
`timescale 1ns/1ps
`include "pich_map.svh"
module pich_host (
  input wire logic CLK, // 25 MHz system clock
  input wire logic RESET_N, // synchronous reset, active low
  input wire logic [2:0] AVS_ADDRESS, // avalon word index
  input wire logic AVS_READ, // avalon read request
  input wire logic AVS_WRITE, // avalon write request
  input wire logic [31:0] AVS_WRITEDATA, // avalon write data
  output logic [31:0] AVS_READDATA, // avalon read data, registered
  output logic AVS_WAITREQUEST, // avalon stall
  output logic PIC_CS_N, // device chip select, active low
  output logic PIC_RD_N, // device read strobe, active low
  output logic PIC_WR_N, // device write strobe, active low
  output logic PIC_INT_ACK_N, // device acknowledge strobe, active low
  output logic PIC_ADDR_BIT0, // device register select
  output logic [7:0] PIC_D_OUT, // data bus, driven value
  output logic PIC_D_OE_N, // data bus enable, low while driving
  input wire logic [7:0] PIC_D_IN, // data bus, sampled value
  input wire logic PIC_INT // device interrupt output
);
  typedef struct packed {
    pich_pkg::pich_state_type st;
    pich_pkg::pich_op_type op;
    logic step;
    logic a0;
    logic [7:0] arg;
    logic start;
    pich_pkg::pich_cyc_type kind;
    logic [7:0] data;
    logic [7:0] vector;
    logic [7:0] poll;
    logic int_at_ack;
    logic spurious;
    logic eoi_owed;
    logic [2:0] owed_level;
    logic [1:0] ctrl;
    logic rd_valid;
    logic [31:0] readdata;
  } pich_host_type;

  pich_host_type s_q;
  pich_host_type s_d;
  pich_cyc_if cyc ();

  logic cmd_hit;
  logic [31:0] status_word;

  pich_cycle u_cycle (
    .clk(CLK),
    .reset_n(RESET_N),
    .cyc(cyc.eng),
    .cs_n(PIC_CS_N),
    .rd_n(PIC_RD_N),
    .wr_n(PIC_WR_N),
    .int_ack_n(PIC_INT_ACK_N),
    .addr_bit0(PIC_ADDR_BIT0),
    .d_out(PIC_D_OUT),
    .d_oe_n(PIC_D_OE_N),
    .d_in(PIC_D_IN)
  );

  // a command is only taken while the sequencer is idle; otherwise stall
  assign cmd_hit = AVS_WRITE && (AVS_ADDRESS == `PICH_REG_CMD);
  assign AVS_WAITREQUEST = AVS_READ ? !s_q.rd_valid : (cmd_hit && s_q.st != pich_pkg::ST_IDLE);
  assign AVS_READDATA = s_q.readdata;

  // status: busy, interrupt pin, end owed, level owed, spurious acknowledge
  assign status_word = {24'h0000_00, s_q.spurious, s_q.owed_level, s_q.eoi_owed, PIC_INT,
                        s_q.st != pich_pkg::ST_IDLE, 1'b0} >> 1;

  // register readback decode
  function automatic logic [31:0] reg_read(input logic [2:0] idx, input pich_host_type s,
                                           input logic [31:0] stat);
    case (idx)
      `PICH_REG_STATUS: reg_read = stat;
      `PICH_REG_DATA: reg_read = {24'h0000_00, s.data};
      `PICH_REG_VECTOR: reg_read = {24'h0000_00, s.vector};
      `PICH_REG_POLL: reg_read = {24'h0000_00, s.poll};
      `PICH_REG_CTRL: reg_read = {24'h0000_00, 6'h00, s.ctrl};
      default: reg_read = 32'h0000_0000;
    endcase
  endfunction : reg_read

  // one pin cycle request, issued on the next edge
  function automatic pich_host_type issue(input pich_host_type s, input pich_pkg::pich_cyc_type k,
                                          input logic a0, input logic [7:0] b);
    issue = s;
    issue.start = 1'b1;
    issue.kind = k;
    issue.a0 = a0;
    issue.arg = b;
    issue.st = pich_pkg::ST_RUN;
  endfunction : issue

  // sequencer, avalon slave and bookkeeping
  always_comb begin
    s_d = s_q;
    s_d.start = 1'b0;
    // two-cycle read: first edge loads readdata, second completes
    s_d.rd_valid = AVS_READ && !s_q.rd_valid;
    if (AVS_READ && !s_q.rd_valid) begin
      s_d.readdata = reg_read(AVS_ADDRESS, s_q, status_word);
    end
    if (AVS_WRITE && AVS_ADDRESS == `PICH_REG_CTRL) begin
      s_d.ctrl = AVS_WRITEDATA[1:0];
    end
    case (s_q.st)
      pich_pkg::ST_IDLE: begin
        if (cmd_hit) begin
          s_d.op = pich_pkg::pich_op_type'(AVS_WRITEDATA[`PICH_CMD_OP_LSB +: 3]);
          s_d.step = 1'b0;
          case (s_d.op)
            pich_pkg::OP_WRITE: begin
              // rotation, priority-set and end words pass through unchanged
              s_d = issue(s_d, pich_pkg::CYC_WRITE, AVS_WRITEDATA[`PICH_CMD_A0_BIT],
                          AVS_WRITEDATA[7:0]);
            end
            pich_pkg::OP_READ: begin
              // address bit picks mask or the selected request/in-service view
              s_d = issue(s_d, pich_pkg::CYC_READ, AVS_WRITEDATA[`PICH_CMD_A0_BIT],
                          8'h00);
            end
            pich_pkg::OP_ACK: begin
              s_d.int_at_ack = PIC_INT;
              s_d = issue(s_d, pich_pkg::CYC_ACK, 1'b0, 8'h00);
            end
            pich_pkg::OP_POLL: begin
              // poll word first; the acknowledge path is idle meanwhile
              s_d = issue(s_d, pich_pkg::CYC_WRITE, 1'b0, `PICH_POLL_WORD);
            end
            pich_pkg::OP_EOI: begin
              // always the specific form, so a rotated priority never ends the wrong level
              s_d = issue(s_d, pich_pkg::CYC_WRITE, 1'b0,
                          `PICH_SPEC_EOI_BASE | {5'h00, AVS_WRITEDATA[2:0]});
            end
            default: s_d.st = pich_pkg::ST_IDLE;
          endcase
        end else if (s_q.ctrl[`PICH_CTRL_AUTO_ACK] && PIC_INT && !s_q.eoi_owed) begin
          // auto service answers the interrupt output unless an end is still owed
          s_d.op = pich_pkg::OP_ACK;
          s_d.step = 1'b0;
          s_d.int_at_ack = 1'b1;
          s_d = issue(s_d, pich_pkg::CYC_ACK, 1'b0, 8'h00);
        end
      end
      pich_pkg::ST_RUN: begin
        s_d.st = pich_pkg::ST_WAIT;
      end
      pich_pkg::ST_WAIT: begin
        if (cyc.done) begin
          s_d.st = pich_pkg::ST_IDLE;
          case (s_q.op)
            pich_pkg::OP_READ: begin
              s_d.data = cyc.rdata;
            end
            pich_pkg::OP_ACK: begin
              if (!s_q.step) begin
                s_d.step = 1'b1;
                s_d = issue(s_d, pich_pkg::CYC_ACK, 1'b0, 8'h00);
              end else begin
                s_d.vector = cyc.rdata;
                // a low interrupt output at acknowledge means an incomplete request
                s_d.spurious = !s_q.int_at_ack;
                s_d.owed_level = s_q.int_at_ack ? cyc.rdata[2:0] : `PICH_SPURIOUS_LEVEL;
                // auto mode and the incomplete handler both owe nothing
                s_d.eoi_owed = s_q.int_at_ack && !s_q.ctrl[`PICH_CTRL_AEOI];
              end
            end
            pich_pkg::OP_POLL: begin
              if (!s_q.step) begin
                s_d.step = 1'b1;
                // polling read always at address 0 so nesting stays consistent
                s_d = issue(s_d, pich_pkg::CYC_READ, 1'b0, 8'h00);
              end else begin
                s_d.poll = cyc.rdata;
                // a pending level is now in service and must be ended later
                if (cyc.rdata[`PICH_POLL_PEND_BIT]) begin
                  s_d.eoi_owed = 1'b1;
                  s_d.owed_level = cyc.rdata[2:0];
                  s_d.spurious = 1'b0;
                end
              end
            end
            pich_pkg::OP_EOI: begin
              s_d.eoi_owed = 1'b0;
            end
            default: s_d.st = pich_pkg::ST_IDLE;
          endcase
        end
      end
      default: s_d.st = pich_pkg::ST_IDLE;
    endcase
    if (!RESET_N) begin
      s_d = '0;
      s_d.st = pich_pkg::ST_IDLE;
      s_d.op = pich_pkg::OP_WRITE;
      s_d.kind = pich_pkg::CYC_WRITE;
      s_d.ctrl = `PICH_CTRL_RESET;
    end
  end

  // state register
  always_ff @(posedge CLK) begin
    s_q <= s_d;
  end

  assign cyc.start = s_q.start;
  assign cyc.kind = s_q.kind;
  assign cyc.a0 = s_q.a0;
  assign cyc.wdata = s_q.arg;
endmodule : pich_host

// File: design/pich_map.svh
// register offsets, field positions and pin timing for the interrupt unit host controller
`ifndef PICH_MAP_SVH
`define PICH_MAP_SVH

// clock
`define PICH_CLK_NS 40
// least times on the device pins, in ns
`define PICH_RD_LOW_NS 160
`define PICH_WR_LOW_NS 120
`define PICH_ACK_LOW_NS 160
`define PICH_RECOVER_NS 250
// least times round up to whole cycles
`define PICH_CYC(ns) (((ns) + `PICH_CLK_NS - 1) / `PICH_CLK_NS)

// avalon word indices (byte address is four times these)
`define PICH_REG_CMD 3'h0
`define PICH_REG_STATUS 3'h1
`define PICH_REG_DATA 3'h2
`define PICH_REG_VECTOR 3'h3
`define PICH_REG_POLL 3'h4
`define PICH_REG_CTRL 3'h5

// command register fields
`define PICH_CMD_A0_BIT 8
`define PICH_CMD_OP_LSB 9
// control register fields and reset value
`define PICH_CTRL_AUTO_ACK 0
`define PICH_CTRL_AEOI 1
`define PICH_CTRL_RESET 2'h0

// command words sent to the device, the pending bit of the poll answer and the spurious level
`define PICH_POLL_WORD 8'h0C
`define PICH_SPEC_EOI_BASE 8'h60
`define PICH_POLL_PEND_BIT 7
`define PICH_SPURIOUS_LEVEL 3'h7

`endif

// File: design/pich_pkg.sv
// types shared by the interrupt unit host controller
package pich_pkg;
  typedef enum logic [1:0] {CYC_WRITE, CYC_READ, CYC_ACK} pich_cyc_type;
  typedef enum {PH_IDLE, PH_LOW, PH_REC} pich_phase_type;
  typedef enum {ST_IDLE, ST_RUN, ST_WAIT} pich_state_type;
  typedef enum logic [2:0] {
    OP_WRITE = 3'h0,
    OP_READ = 3'h1,
    OP_ACK = 3'h2,
    OP_POLL = 3'h3,
    OP_EOI = 3'h4
  } pich_op_type;
endpackage : pich_pkg

// File: sim/pich_dev_model.sv
// behavioural model of the eight-input interrupt unit at the host pins
`timescale 1ns/1ps
module pich_dev_model #(
  parameter logic [7:0] VEC_BASE = 8'h40 // arbitrary vector base
) (
  input wire logic clk, // bench clock, only to look at pins
  input wire logic cs_n, // chip select
  input wire logic rd_n, // read strobe
  input wire logic wr_n, // write strobe
  input wire logic int_ack_n, // acknowledge strobe
  input wire logic addr_bit0, // register select
  input wire logic [7:0] d_wr, // host bus value
  input wire logic d_oe_n, // host bus enable
  input wire logic [7:0] irq_in, // peripheral requests
  input wire logic edge_mode, // 1 edge, 0 level trigger
  input wire logic auto_eoi_enable, // auto end mode
  output logic [7:0] d_rd, // device bus value
  output logic int_out // interrupt output
);
  logic [7:0] request_latch_reg = 8'h00, in_service_reg = 8'h00, mask_reg = 8'h00;
  logic [7:0] wd = 8'h00, last_q = 8'h00, p_irq = 8'h00, val;
  logic [2:0] low_lvl = 3'h7, ack_lvl = 3'h7, lv;
  logic rot_auto = 0, readback_select = 0, poll_phase = 0, p_ack = 1, p_wr = 1, p_rd = 1, drv;
  logic [1:0] ack_cnt = 2'h0;
  logic [3:0] hit, sv;
  // first level in rank order; a level in service ends the scan
  function automatic logic [3:0] pick(input logic [7:0] req, input logic [7:0] svc,
                                      input logic [2:0] lo);
    logic [2:0] l;
    logic stop;
    pick = 4'h0;
    stop = 1'b0;
    for (int k = 1; k < 9; k++) begin
      l = lo + 3'(k);
      if (!stop && (svc[l] || req[l])) begin
        stop = 1'b1;
        if (!svc[l]) pick = {1'b1, l};
      end
    end
  endfunction : pick
  // outputs; a released bus shows the inverse of its last value
  assign hit = pick(request_latch_reg & ~mask_reg, in_service_reg, low_lvl);
  assign int_out = hit[3];
  assign drv = (!cs_n && !rd_n) || !int_ack_n;
  assign val = !int_ack_n ? (VEC_BASE | {5'h00, ack_lvl}) : addr_bit0 ? mask_reg
    : poll_phase ? {hit[3], 4'h0, hit[2:0]}
    : readback_select ? in_service_reg : request_latch_reg;
  assign d_rd = drv ? val : ~last_q;
  // pins looked at on the falling edge, clear of the host's launches
  always @(negedge clk) begin
    if (edge_mode) request_latch_reg |= irq_in & ~p_irq;
    else request_latch_reg = irq_in;
    if (!int_ack_n && p_ack && ack_cnt == 2'h0) begin
      ack_lvl = int_out ? hit[2:0] : 3'h7;
      if (int_out) in_service_reg[ack_lvl] = 1'b1;
      if (int_out) request_latch_reg[ack_lvl] = 1'b0;
    end
    if (int_ack_n && !p_ack) ack_cnt++;
    if (ack_cnt == 2'h2) begin
      ack_cnt = 2'h0;
      if (auto_eoi_enable) in_service_reg[ack_lvl] = 1'b0;
      if (auto_eoi_enable && rot_auto) low_lvl = ack_lvl;
    end
    if ((wr_n | cs_n) && !p_wr) begin
      sv = pick(in_service_reg, 8'h00, low_lvl);
      lv = wd[6] ? wd[2:0] : sv[2:0];
      if (addr_bit0) mask_reg = wd;
      else if (wd[4:3] == 2'h1) begin
        if (wd[2]) poll_phase = 1'b1;
        if (wd[1]) readback_select = wd[0];
      end else if (wd[4:3] == 2'h0) begin
        case (wd[7:5])
          3'h1, 3'h3, 3'h5, 3'h7: begin
            if (wd[6] || sv[3]) in_service_reg[lv] = 1'b0;
            if (wd[7] && (wd[6] || sv[3])) low_lvl = lv;
          end
          3'h6: low_lvl = wd[2:0];
          3'h4: rot_auto = rot_auto | auto_eoi_enable;
          3'h0: rot_auto = rot_auto & !auto_eoi_enable;
          default: ;
        endcase
      end
    end
    if ((rd_n | cs_n) && !p_rd && poll_phase) begin
      poll_phase = 1'b0;
      if (hit[3]) in_service_reg[hit[2:0]] = 1'b1;
      if (hit[3]) request_latch_reg[hit[2:0]] = 1'b0;
    end
    if (drv) last_q = val;
    if (!d_oe_n) wd = d_wr;
    p_irq = irq_in;
    p_ack = int_ack_n;
    p_wr = wr_n | cs_n;
    p_rd = rd_n | cs_n;
  end
endmodule : pich_dev_model

// File: sim/pich_host_asserts.sv
// pin and bus timing checks for the interrupt unit host controller
`timescale 1ns/1ps
module pich_host_asserts (
  input wire logic CLK, // clock
  input wire logic RESET_N, // reset, active low
  input wire logic AVS_READ, // read request
  input wire logic AVS_WAITREQUEST, // stall
  input wire logic PIC_CS_N, // chip select
  input wire logic PIC_RD_N, // read strobe
  input wire logic PIC_WR_N, // write strobe
  input wire logic PIC_INT_ACK_N, // acknowledge strobe
  input wire logic PIC_ADDR_BIT0, // register select
  input wire logic [7:0] PIC_D_OUT, // bus value
  input wire logic PIC_D_OE_N // bus enable
);
  wire all_high = PIC_RD_N & PIC_WR_N & PIC_INT_ACK_N;
  default clocking cb @(posedge CLK); endclocking
  default disable iff (!RESET_N);
  // strobe widths are fixed by the pin engine
  property p_wr_len; $fell(PIC_WR_N) |-> (!PIC_WR_N) [*3] ##1 PIC_WR_N; endproperty
  a_wr_len: assert property (p_wr_len) else $error("write strobe width wrong");
  property p_rd_len; $fell(PIC_RD_N) |-> (!PIC_RD_N) [*4] ##1 PIC_RD_N; endproperty
  a_rd_len: assert property (p_rd_len) else $error("read strobe width wrong");
  property p_ack_len; $fell(PIC_INT_ACK_N) |-> (!PIC_INT_ACK_N) [*4] ##1 PIC_INT_ACK_N; endproperty
  a_ack_len: assert property (p_ack_len) else $error("ack strobe width wrong");
  // recovery keeps the device from seeing strobes too close
  property p_recover; $rose(all_high) |-> all_high [*7]; endproperty
  a_recover: assert property (p_recover) else $error("strobe recovery too short");
  property p_one; $onehot0({!PIC_RD_N, !PIC_WR_N, !PIC_INT_ACK_N}); endproperty
  a_one: assert property (p_one) else $error("two strobes low together");
  property p_cs; PIC_CS_N == (PIC_RD_N && PIC_WR_N); endproperty
  a_cs: assert property (p_cs) else $error("chip select not with strobe");
  property p_oe; PIC_D_OE_N == PIC_WR_N; endproperty
  a_oe: assert property (p_oe) else $error("bus enable not with write");
  // the register choice must not move under a strobe
  property p_rd_a0; $fell(PIC_RD_N) |=> $stable(PIC_ADDR_BIT0) [*3]; endproperty
  a_rd_a0: assert property (p_rd_a0) else $error("select moved during read");
  property p_wr_d; $fell(PIC_WR_N) |=> ($stable(PIC_D_OUT) && $stable(PIC_ADDR_BIT0)) [*2]; endproperty
  a_wr_d: assert property (p_wr_d) else $error("data moved during write");
  property p_wait; AVS_READ && AVS_WAITREQUEST |=> !AVS_WAITREQUEST; endproperty
  a_wait: assert property (p_wait) else $error("read answer late");
endmodule : pich_host_asserts
bind pich_host pich_host_asserts u_chk (.CLK(CLK), .RESET_N(RESET_N), .AVS_READ(AVS_READ),
  .AVS_WAITREQUEST(AVS_WAITREQUEST), .PIC_CS_N(PIC_CS_N), .PIC_RD_N(PIC_RD_N),
  .PIC_WR_N(PIC_WR_N), .PIC_INT_ACK_N(PIC_INT_ACK_N), .PIC_ADDR_BIT0(PIC_ADDR_BIT0),
  .PIC_D_OUT(PIC_D_OUT), .PIC_D_OE_N(PIC_D_OE_N));

// File: sim/pich_host_tb.sv
// self-checking bench for the interrupt unit host controller
`timescale 1ns/1ps
`include "pich_map.svh"
module pich_host_tb;
  logic clk = 1'b0;
  logic rst_n = 1'b0;
  logic a_rd = 1'b0;
  logic a_wr = 1'b0;
  logic [2:0] a_adr = 3'h0;
  logic [31:0] a_wd = 32'h0000_0000;
  logic [31:0] a_q;
  logic a_wait, cs_n, rd_n, wr_n, ack_n, a0, oe_n, int_o;
  logic [7:0] d_o, d_i;
  logic [7:0] irq = 8'h00;
  logic edge_m = 1'b1;
  logic aeoi = 1'b0;
  int failures = 0;
  int cmp_count = 0;
  pich_host u_dut (.CLK(clk), .RESET_N(rst_n), .AVS_ADDRESS(a_adr), .AVS_READ(a_rd),
    .AVS_WRITE(a_wr), .AVS_WRITEDATA(a_wd), .AVS_READDATA(a_q), .AVS_WAITREQUEST(a_wait),
    .PIC_CS_N(cs_n), .PIC_RD_N(rd_n), .PIC_WR_N(wr_n), .PIC_INT_ACK_N(ack_n),
    .PIC_ADDR_BIT0(a0), .PIC_D_OUT(d_o), .PIC_D_OE_N(oe_n), .PIC_D_IN(d_i), .PIC_INT(int_o));
  pich_dev_model u_dev (.clk(clk), .cs_n(cs_n), .rd_n(rd_n), .wr_n(wr_n), .int_ack_n(ack_n),
    .addr_bit0(a0), .d_wr(d_o), .d_oe_n(oe_n), .irq_in(irq), .edge_mode(edge_m),
    .auto_eoi_enable(aeoi), .d_rd(d_i), .int_out(int_o));
  initial forever #20 clk = ~clk;
  task automatic test_done();
    if (failures == 0 && cmp_count > 0) begin
      $display("All tests passed");
    end else begin
      $display("Some tests failed");
    end
    $finish;
  endtask : test_done
  task automatic chk(input logic [7:0] g, input logic [7:0] e);
    cmp_count++;
    if (g !== e) begin
      failures++;
      $display("BAD %0t got %h exp %h", $time, g, e);
    end
  endtask : chk
  // one avalon transfer; request held until waitrequest is seen low at a rising edge,
  // read data taken at that same edge, then one idle edge before the next request
  task automatic av(input logic w, input logic [2:0] a, input logic [31:0] d,
                    output logic [31:0] q);
    a_adr <= a;
    a_wd <= d;
    a_wr <= w;
    a_rd <= !w;
    do @(posedge clk); while (a_wait !== 1'b0);
    q = a_q;
    a_wr <= 1'b0;
    a_rd <= 1'b0;
    @(posedge clk);
  endtask : av
  task automatic reg_chk(input logic [2:0] r, input logic [7:0] e);
    logic [31:0] q;
    av(1'b0, r, 32'h0000_0000, q);
    chk(q[7:0], e);
  endtask : reg_chk
  // device cycle: order it, then wait until busy clears
  task automatic cmd(input pich_pkg::pich_op_type op, input logic a, input logic [7:0] b);
    logic [31:0] q;
    av(1'b1, `PICH_REG_CMD, {20'h0_0000, op, a, b}, q);
    do av(1'b0, `PICH_REG_STATUS, 32'h0000_0000, q); while (q[0] !== 1'b0);
  endtask : cmd
  task automatic get(input pich_pkg::pich_op_type op, input logic [2:0] r, input logic [7:0] e);
    cmd(op, 1'b0, 8'h00);
    reg_chk(r, e);
  endtask : get
  task automatic rdv(input logic a, input logic [7:0] e);
    cmd(pich_pkg::OP_READ, a, 8'h00);
    reg_chk(`PICH_REG_DATA, e);
  endtask : rdv
  task automatic put(input logic a, input logic [7:0] b);
    cmd(pich_pkg::OP_WRITE, a, b);
  endtask : put
  // let the interrupt line settle before acknowledging
  task automatic ack(input logic [7:0] e);
    repeat (4) @(posedge clk);
    get(pich_pkg::OP_ACK, `PICH_REG_VECTOR, e);
  endtask : ack
  // drop then raise requests so edge mode sees fresh rises
  task automatic rearm(input logic [7:0] lo, input logic [7:0] hi);
    irq <= lo;
    repeat (2) @(posedge clk);
    irq <= hi;
    @(posedge clk);
  endtask : rearm
  initial begin
    repeat (20000) @(posedge clk);
    failures++;
    test_done();
  end
  initial begin
    logic [31:0] q;
    repeat (3) @(posedge clk);
    rst_n <= 1'b1;
    repeat (2) @(posedge clk);
    reg_chk(`PICH_REG_CTRL, 8'h00);
    reg_chk(3'h7, 8'h00);
    ack(8'h47);
    reg_chk(`PICH_REG_STATUS, 8'h78);
    put(1'b0, 8'h0B);
    rdv(1'b0, 8'h00);
    put(1'b1, 8'h21);
    rdv(1'b1, 8'h21);
    irq <= 8'h24;
    put(1'b0, 8'h0A);
    rdv(1'b0, 8'h24);
    ack(8'h42);
    put(1'b0, 8'h0B);
    rdv(1'b0, 8'h04);
    put(1'b1, 8'h00);
    av(1'b0, `PICH_REG_STATUS, 32'h0000_0000, q);
    chk({7'h00, q[1]}, 8'h00);
    irq <= 8'h26;
    ack(8'h41);
    rdv(1'b0, 8'h06);
    put(1'b0, 8'h20);
    rdv(1'b0, 8'h04);
    put(1'b0, 8'h62);
    rdv(1'b0, 8'h00);
    irq <= 8'h20;
    get(pich_pkg::OP_POLL, `PICH_REG_POLL, 8'h85);
    reg_chk(`PICH_REG_STATUS, 8'h2C);
    rdv(1'b0, 8'h20);
    cmd(pich_pkg::OP_EOI, 1'b0, 8'h05);
    rdv(1'b0, 8'h00);
    put(1'b0, 8'h0A);
    rdv(1'b0, 8'h00);
    rearm(8'h00, 8'h81);
    put(1'b0, 8'hC4);
    rdv(1'b0, 8'h81);
    ack(8'h47);
    put(1'b0, 8'hA0);
    rearm(8'h01, 8'h81);
    ack(8'h40);
    put(1'b0, 8'h0B);
    rdv(1'b0, 8'h01);
    put(1'b0, 8'hE0);
    rearm(8'h80, 8'h81);
    ack(8'h47);
    put(1'b0, 8'h67);
    rdv(1'b0, 8'h00);
    irq <= 8'h00;
    aeoi <= 1'b1;
    av(1'b1, `PICH_REG_CTRL, 32'h0000_0002, q);
    reg_chk(`PICH_REG_CTRL, 8'h02);
    put(1'b0, 8'h80);
    irq <= 8'h08;
    ack(8'h43);
    rdv(1'b0, 8'h00);
    irq <= 8'h1C;
    ack(8'h44);
    put(1'b0, 8'h00);
    edge_m <= 1'b0;
    irq <= 8'h40;
    ack(8'h46);
    put(1'b0, 8'h0A);
    rdv(1'b0, 8'h40);
    // auto acknowledge: one fresh edge request, answered without software
    irq <= 8'h00;
    repeat (2) @(posedge clk);
    edge_m <= 1'b1;
    av(1'b1, `PICH_REG_CTRL, 32'h0000_0003, q);
    irq <= 8'h02;
    repeat (80) @(posedge clk);
    reg_chk(`PICH_REG_VECTOR, 8'h41);
    reg_chk(`PICH_REG_STATUS, 8'h08);
    test_done();
  end
endmodule : pich_host_tb
